// *** rtl/lapb_pkg.sv ***
// How it works
// R1: Default ack sends a ready I frame, else RR with final bit clear.
// R2: Optional send sends a ready I frame, else nothing at all.
// R3: Busy default sends a ready I frame, else RNR with final bit clear.
// R4: Poll while busy gets RNR F=1; else I frame or RNR F=0.
// R5: Errors in frame reject resend FRMR with F=P to commands; a response means silence.
// R6: Errors while disconnected send DM F=1 only on poll, else nothing.
// R7: Send-sequence error sends REJ F=P, or RR F=1 on poll if REJ pending.
// R8: Busy clear sends REJ F=0 if data was dropped, else RR F=0.
// R9: Impossible state and event pairs are ignored.
// R10: One state register, one frame and poll/final bit per event.
// R11: Local stop sends DISC into disconnect request; start sends SABM into setup.
package lapb_pkg;

	localparam int EV_W   = 5;
	localparam int KIND_W = 4;
	localparam int ST_W   = 4;
	// Event sample: valid, code, poll/final, command flag, I frame ready.
	localparam int SMP_W  = 1 + EV_W + 1 + 1 + 1;

	// Link states, Gray coded along setup, transfer and the busy variants.
	typedef enum logic [ST_W-1:0] {
		ST_DISC      = 4'h0,
		ST_SETUP     = 4'h1,
		ST_INFO      = 4'h3,
		ST_WAIT      = 4'h2,
		ST_REJ       = 4'h6,
		ST_RBUSY     = 4'h7,
		ST_LBUSY     = 4'h5,
		ST_BOTH      = 4'h4,
		ST_WAIT_L    = 4'hc,
		ST_WAIT_R    = 4'hd,
		ST_WAIT_LR   = 4'hf,
		ST_REJ_R     = 4'he,
		ST_FRMR      = 4'ha,
		ST_DISC_REQ  = 4'hb
	} link_state_t;

	typedef enum logic [EV_W-1:0] {
		EV_I_CMD    = 5'h00,
		EV_RR_CMD   = 5'h01,
		EV_REJ_CMD  = 5'h02,
		EV_RNR_CMD  = 5'h03,
		EV_SABM     = 5'h04,
		EV_DISC     = 5'h05,
		EV_RR_RSP   = 5'h06,
		EV_REJ_RSP  = 5'h07,
		EV_RNR_RSP  = 5'h08,
		EV_UA       = 5'h09,
		EV_DM       = 5'h0a,
		EV_FRMR     = 5'h0b,
		EV_START    = 5'h0c,
		EV_STOP     = 5'h0d,
		EV_BUSY_SET = 5'h0e,
		EV_BUSY_CLR = 5'h0f,
		EV_T1       = 5'h10,
		EV_N2       = 5'h11,
		EV_NS_ERR   = 5'h12,
		EV_NR_INV   = 5'h13,
		EV_UNREC    = 5'h14
	} event_t;

	typedef enum logic [KIND_W-1:0] {
		FR_NONE = 4'h0,
		FR_I    = 4'h1,
		FR_RR   = 4'h2,
		FR_RNR  = 4'h3,
		FR_REJ  = 4'h4,
		FR_SABM = 4'h5,
		FR_DISC = 4'h6,
		FR_UA   = 4'h7,
		FR_DM   = 4'h8,
		FR_FRMR = 4'h9
	} frame_kind_t;

	localparam link_state_t ST_RESET   = ST_DISC;
	localparam logic [SMP_W-1:0] SMP_RESET = 9'h000;

endpackage

// *** rtl/link_sampler.sv ***
`timescale 1ns/1ps
// Brings the link clock and the event pins into the core clock and
// marks each rising edge of the link clock with a one-cycle strobe.
module link_sampler (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      link_clk,
	input  wire logic [lapb_pkg::SMP_W-1:0] din,
	output logic                           stb,
	output logic [lapb_pkg::SMP_W-1:0]     dout
);
	import lapb_pkg::*;

	logic [2:0]       lck_r;
	logic [SMP_W-1:0] d_meta_r;
	logic [SMP_W-1:0] d_sync_r;

	// Pins are held for a whole link clock period, so the two-stage copy
	// is settled by the time the synchronised rising edge arrives.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lck_r    <= 3'h0;
			d_meta_r <= SMP_RESET;
			d_sync_r <= SMP_RESET;
		end else begin
			lck_r    <= {lck_r[1:0], link_clk};
			d_meta_r <= din;
			d_sync_r <= d_meta_r;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stb  <= 1'b0;
			dout <= SMP_RESET;
		end else begin
			stb  <= lck_r[1] & ~lck_r[2];
			dout <= d_sync_r;
		end
	end

endmodule

// *** rtl/lapb_link_state_responder.sv ***
`timescale 1ns/1ps
module lapb_link_state_responder (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 link_clk,
	input  wire logic                 ev_valid,
	input  wire logic [lapb_pkg::EV_W-1:0] ev_code,
	input  wire logic                 ev_pf,
	input  wire logic                 ev_cmd,
	input  wire logic                 i_ready,
	output logic                      tx_valid,
	output lapb_pkg::frame_kind_t     tx_kind,
	output logic                      tx_pf,
	output lapb_pkg::link_state_t     link_state,
	output logic                      rej_outstanding,
	output logic                      info_dropped
);
	import lapb_pkg::*;

	// ==========================================================
	// Decoding helpers
	function automatic logic is_conn(input link_state_t s);
		is_conn = !(s inside {ST_DISC, ST_SETUP, ST_FRMR, ST_DISC_REQ});
	endfunction

	function automatic link_state_t enc(input logic w, input logic l, input logic r,
		input logic j);
		if (j && !w && !l) begin
			enc = r ? ST_REJ_R : ST_REJ;
		end else begin
			case ({w, l, r})
				3'h0:    enc = ST_INFO;
				3'h1:    enc = ST_RBUSY;
				3'h2:    enc = ST_LBUSY;
				3'h3:    enc = ST_BOTH;
				3'h4:    enc = ST_WAIT;
				3'h5:    enc = ST_WAIT_R;
				3'h6:    enc = ST_WAIT_L;
				default: enc = ST_WAIT_LR;
			endcase
		end
	endfunction

	// ==========================================================
	// Event capture on link clock edges
	logic             stb;
	logic [SMP_W-1:0] smp;

	link_sampler u_sampler (
		.clk      (clk),
		.rst_b    (rst_b),
		.link_clk (link_clk),
		.din      ({ev_valid, ev_code, ev_pf, ev_cmd, i_ready}),
		.stb      (stb),
		.dout     (smp)
	);

	logic        take;
	event_t      ev;
	logic        pf, cmd, irdy, conn;
	logic        fw, fl, fr, fj;

	assign take = stb & smp[SMP_W-1];
	assign ev   = event_t'(smp[SMP_W-2 -: EV_W]);
	assign pf   = smp[2];
	assign cmd  = smp[1];
	assign irdy = smp[0];
	assign conn = is_conn(link_state);
	// Waiting, local busy, remote busy and reject sent, as separate flags.
	assign fw   = link_state inside {ST_WAIT, ST_WAIT_R, ST_WAIT_L, ST_WAIT_LR};
	assign fl   = link_state inside {ST_LBUSY, ST_BOTH, ST_WAIT_L, ST_WAIT_LR};
	assign fr   = link_state inside {ST_RBUSY, ST_BOTH, ST_WAIT_R, ST_WAIT_LR, ST_REJ_R};
	assign fj   = link_state inside {ST_REJ, ST_REJ_R};

	// ==========================================================
	// Response table
	link_state_t st_nxt;
	frame_kind_t kind_nxt, dflt_rr, dflt_rnr, opt_i;
	logic        pf_nxt, drop_nxt, rejo_nxt, leave;
	logic        nw, nl, nr, nj;

	// R1 default ack
	assign dflt_rr  = irdy ? FR_I : FR_RR;
	// R3 busy default
	assign dflt_rnr = irdy ? FR_I : FR_RNR;
	// R2 optional send
	assign opt_i    = irdy ? FR_I : FR_NONE;

	// R10 state and reply
	always_comb begin
		st_nxt   = link_state;
		kind_nxt = FR_NONE;
		pf_nxt   = 1'b0;
		drop_nxt = info_dropped;
		rejo_nxt = rej_outstanding;
		{nw, nl, nr, nj} = {fw, fl, fr, fj};
		leave    = 1'b0;
		case (ev)
			EV_I_CMD, EV_RR_CMD, EV_REJ_CMD, EV_RNR_CMD: begin
				if (link_state == ST_DISC) begin
					if (pf) begin
						kind_nxt = FR_DM;
						pf_nxt   = 1'b1;
					end
				end else if (link_state == ST_FRMR) begin
					kind_nxt = FR_FRMR;
					pf_nxt   = pf;
				end else if (conn) begin
					if (ev == EV_I_CMD) begin
						nj       = 1'b0;
						rejo_nxt = 1'b0;
						drop_nxt = info_dropped | fl;
					end
					nr     = (ev == EV_I_CMD) ? fr : (ev == EV_RNR_CMD);
					pf_nxt = pf;
					if (pf) begin
						// R4 poll while busy
						kind_nxt = fl ? FR_RNR : FR_RR;
					end else if (fl) begin
						// R4 no poll busy
						kind_nxt = (fw || ev == EV_I_CMD || ev == EV_RNR_CMD) ? FR_RNR : dflt_rnr;
					end else begin
						kind_nxt = (fw || nr) ? FR_RR : dflt_rr;
					end
				end
			end
			EV_SABM: begin
				kind_nxt = (link_state == ST_DISC_REQ) ? FR_DM : FR_UA;
				pf_nxt   = pf;
				if (link_state == ST_DISC_REQ) begin
					st_nxt = ST_DISC;
				end else if (link_state != ST_SETUP) begin
					st_nxt = (conn && fl) ? ST_LBUSY : ST_INFO;
				end
				leave = 1'b1;
			end
			EV_DISC: begin
				kind_nxt = (link_state == ST_DISC || link_state == ST_SETUP) ? FR_DM : FR_UA;
				pf_nxt   = pf;
				if (link_state != ST_DISC_REQ) begin
					st_nxt = ST_DISC;
				end
				leave = 1'b1;
			end
			EV_RR_RSP, EV_REJ_RSP, EV_RNR_RSP: begin
				if (conn) begin
					if (pf && !fw) begin
						kind_nxt = FR_SABM;
						st_nxt   = ST_SETUP;
						leave    = 1'b1;
					end else begin
						nw = fw & ~pf;
						nr = (ev == EV_RNR_RSP);
						// R2 optional send
						if (ev != EV_RNR_RSP && (pf || !fw)) begin
							kind_nxt = opt_i;
						end
					end
				end
			end
			EV_UA, EV_DM, EV_FRMR: begin
				if (link_state == ST_SETUP || link_state == ST_DISC_REQ) begin
					if (ev == EV_UA && link_state == ST_SETUP) begin
						st_nxt = ST_INFO;
					end else if (ev == EV_UA || (ev == EV_DM && pf)) begin
						st_nxt = ST_DISC;
					end
				end else if (conn || link_state == ST_FRMR || ev == EV_DM) begin
					kind_nxt = FR_SABM;
					st_nxt   = ST_SETUP;
				end
				leave = 1'b1;
			end
			EV_START, EV_STOP: begin
				// R11 local start and stop
				if (conn || link_state == ST_DISC || link_state == ST_FRMR) begin
					kind_nxt = (ev == EV_START) ? FR_SABM : FR_DISC;
					st_nxt   = (ev == EV_START) ? ST_SETUP : ST_DISC_REQ;
				end
				leave = 1'b1;
			end
			EV_BUSY_SET: begin
				// R9 ignored when already busy
				if (conn && !fl) begin
					kind_nxt = FR_RNR;
					pf_nxt   = pf;
					nl       = 1'b1;
					nj       = 1'b0;
					rejo_nxt = 1'b0;
				end
			end
			EV_BUSY_CLR: begin
				// R8 busy clears
				if (conn && fl) begin
					kind_nxt = info_dropped ? FR_REJ : FR_RR;
					nl       = 1'b0;
					drop_nxt = 1'b0;
				end
			end
			EV_T1: begin
				pf_nxt = 1'b1;
				if (conn) begin
					kind_nxt = fl ? FR_RNR : FR_RR;
					nw       = 1'b1;
					nj       = 1'b0;
				end else if (link_state == ST_SETUP) begin
					kind_nxt = FR_SABM;
				end else if (link_state == ST_DISC_REQ) begin
					kind_nxt = FR_DISC;
				end else if (link_state == ST_FRMR) begin
					kind_nxt = FR_FRMR;
					pf_nxt   = 1'b0;
				end
			end
			EV_N2: begin
				if (link_state == ST_SETUP || link_state == ST_DISC_REQ) begin
					st_nxt = ST_DISC;
				end else if (link_state != ST_DISC) begin
					kind_nxt = FR_SABM;
					st_nxt   = ST_SETUP;
				end
				leave = 1'b1;
			end
			EV_NS_ERR, EV_NR_INV, EV_UNREC: begin
				if (link_state == ST_DISC) begin
					// R6 disconnected error
					if (cmd && pf) begin
						kind_nxt = FR_DM;
						pf_nxt   = 1'b1;
					end
				end else if (link_state == ST_FRMR) begin
					// R5 frame reject error
					if (cmd) begin
						kind_nxt = FR_FRMR;
						pf_nxt   = pf;
					end
				end else if (conn && ev != EV_NS_ERR) begin
					kind_nxt = FR_FRMR;
					st_nxt   = ST_FRMR;
					leave    = 1'b1;
				end else if (conn && fl) begin
					kind_nxt = FR_RNR;
					pf_nxt   = pf;
				end else if (conn && !rej_outstanding) begin
					// R7 send reject
					kind_nxt = FR_REJ;
					pf_nxt   = pf;
					rejo_nxt = 1'b1;
					nj       = ~fw;
				end else if (conn && pf) begin
					kind_nxt = FR_RR;
					pf_nxt   = 1'b1;
				end
			end
			default: st_nxt = link_state;
		endcase
		if (conn && !leave) begin
			st_nxt = enc(nw, nl, nr, nj);
		end
		if (!is_conn(st_nxt)) begin
			drop_nxt = 1'b0;
			rejo_nxt = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link_state      <= ST_RESET;
			info_dropped    <= 1'b0;
			rej_outstanding <= 1'b0;
		end else if (take) begin
			link_state      <= st_nxt;
			info_dropped    <= drop_nxt;
			rej_outstanding <= rejo_nxt;
		end
	end

	// A frame request is a single-cycle pulse; the transmitter latches it.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_valid <= 1'b0;
			tx_kind  <= FR_NONE;
			tx_pf    <= 1'b0;
		end else begin
			tx_valid <= take && (kind_nxt != FR_NONE);
			if (take) begin
				tx_kind <= kind_nxt;
				tx_pf   <= pf_nxt;
			end
		end
	end

endmodule

// *** bench/lapb_responder_checker.sv ***
`timescale 1ns/1ps
// ============================================================
// Port checker for the link state responder
module lapb_responder_checker (
	input wire logic                  clk,
	input wire logic                  rst_b,
	input wire logic                  tx_valid,
	input wire lapb_pkg::frame_kind_t tx_kind,
	input wire logic                  tx_pf,
	input wire lapb_pkg::link_state_t link_state,
	input wire logic                  rej_outstanding
);
	import lapb_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_pulse;
		tx_valid |=> !tx_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("send strobe longer than one cycle");

	property p_kind;
		tx_valid |-> tx_kind != FR_NONE;
	endproperty
	a_kind: assert property (p_kind) else $error("send strobe without a frame");

	property p_stop;
		link_state == ST_DISC_REQ && $past(link_state) != ST_DISC_REQ
			|-> tx_valid && tx_kind == FR_DISC;
	endproperty
	a_stop: assert property (p_stop) else $error("no disconnect on stop");

	property p_start;
		link_state == ST_SETUP && $past(link_state) == ST_DISC
			|-> tx_valid && tx_kind == FR_SABM && tx_pf == 1'h0;
	endproperty
	a_start: assert property (p_start) else $error("no mode set on start");

	property p_frmr;
		tx_valid && link_state == ST_FRMR && $past(link_state, 2) == ST_FRMR
			|-> tx_kind == FR_FRMR;
	endproperty
	a_frmr: assert property (p_frmr) else $error("wrong frame in reject state");

	property p_disc;
		tx_valid && link_state == ST_DISC && $past(link_state) == ST_DISC
			|-> tx_kind == FR_DM;
	endproperty
	a_disc: assert property (p_disc) else $error("wrong frame while disconnected");

	property p_busy;
		tx_valid && link_state inside {ST_LBUSY, ST_BOTH, ST_WAIT_L, ST_WAIT_LR}
			|-> !(tx_kind inside {FR_RR, FR_REJ});
	endproperty
	a_busy: assert property (p_busy) else $error("ready frame sent while busy");

	property p_rej;
		tx_valid && tx_kind == FR_REJ |-> $past(rej_outstanding, 3) == 1'h0;
	endproperty
	a_rej: assert property (p_rej) else $error("reject repeated while outstanding");
endmodule

// *** bench/remote_station.sv ***
`timescale 1ns/1ps
// ============================================================
// Far station: frames one event on a single link clock period
module remote_station (
	input  wire logic                 clk,
	output logic                      link_clk,
	output logic                      ev_valid,
	output logic [lapb_pkg::EV_W-1:0] ev_code,
	output logic                      ev_pf,
	output logic                      ev_cmd,
	output logic                      i_ready
);
	import lapb_pkg::*;

	initial begin
		link_clk = 1'h0;
		ev_valid = 1'h0;
		ev_code = 5'h00;
		ev_pf = 1'h0;
		ev_cmd = 1'h0;
		i_ready = 1'h0;
	end

	// The link clock stands still between frames, as the far end only clocks data.
	task automatic send(input event_t c, input logic p, m, r);
		@(posedge clk);
		ev_valid <= 1'h1;
		ev_code <= c;
		ev_pf <= p;
		ev_cmd <= m;
		i_ready <= r;
		repeat (4) @(posedge clk);
		link_clk <= 1'h1;
		repeat (4) @(posedge clk);
		link_clk <= 1'h0;
		repeat (4) @(posedge clk);
		// Released lines show the inverse so a stale value is never mistaken for data.
		ev_valid <= 1'h0;
		ev_code <= ~c;
		ev_pf <= ~p;
		ev_cmd <= ~m;
		i_ready <= ~r;
	endtask
endmodule

// *** bench/tb.sv ***
`timescale 1ns/1ps
// ============================================================
// Responder bench
module tb;
	import lapb_pkg::*;
	logic            clk;
	logic            rst_b;
	logic            link_clk;
	logic            ev_valid;
	logic [EV_W-1:0] ev_code;
	logic            ev_pf;
	logic            ev_cmd;
	logic            i_ready;
	logic            tx_valid;
	frame_kind_t     tx_kind;
	logic            tx_pf;
	link_state_t     link_state;
	logic            rej_outstanding;
	logic            info_dropped;
	int              n_mismatch;
	int              samples_checked;
	int              n_tx;

	lapb_link_state_responder lapb_link_state_responder_inst (.clk(clk), .rst_b(rst_b),
		.link_clk(link_clk), .ev_valid(ev_valid), .ev_code(ev_code), .ev_pf(ev_pf),
		.ev_cmd(ev_cmd), .i_ready(i_ready), .tx_valid(tx_valid), .tx_kind(tx_kind),
		.tx_pf(tx_pf), .link_state(link_state), .rej_outstanding(rej_outstanding),
		.info_dropped(info_dropped));

	remote_station remote_station_inst (.clk(clk), .link_clk(link_clk), .ev_valid(ev_valid),
		.ev_code(ev_code), .ev_pf(ev_pf), .ev_cmd(ev_cmd), .i_ready(i_ready));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	// Strobes are counted on the falling edge, well clear of the launching edge.
	always @(negedge clk) begin
		if (tx_valid === 1'h1) n_tx++;
	end

	task automatic ev(input event_t c, input logic p, m, r, input frame_kind_t k,
			input logic f, input link_state_t s);
		int   n0;
		logic ok;
		n0 = n_tx;
		remote_station_inst.send(c, p, m, r);
		repeat (2) @(posedge clk);
		ok = (n_tx - n0) == ((k == FR_NONE) ? 0 : 1);
		if (k != FR_NONE) ok = ok && tx_kind === k && (k inside {FR_I, FR_DISC} || tx_pf === f);
		samples_checked++;
		if (!(ok && link_state === s)) begin
			n_mismatch++;
			$display("FAIL %0t %s gave %s pf %b in %s", $time, c.name(), tx_kind.name(),
				tx_pf, link_state.name());
		end
	endtask

	task automatic chk_drop(input logic e);
		samples_checked++;
		if (info_dropped !== e) begin
			n_mismatch++;
			$display("FAIL %0t dropped flag %b", $time, info_dropped);
		end
	endtask

	task automatic t_disc();
		ev(EV_NS_ERR, 1'h1, 1'h1, 1'h0, FR_DM, 1'h1, ST_DISC);
		ev(EV_NS_ERR, 1'h0, 1'h1, 1'h0, FR_NONE, 1'h0, ST_DISC);
		ev(EV_START, 1'h0, 1'h0, 1'h0, FR_SABM, 1'h0, ST_SETUP);
		ev(EV_UA, 1'h1, 1'h0, 1'h0, FR_NONE, 1'h0, ST_INFO);
		$display("disconnected test done");
	endtask

	task automatic t_ack();
		ev(EV_RR_CMD, 1'h0, 1'h1, 1'h1, FR_I, 1'h0, ST_INFO);
		ev(EV_RR_CMD, 1'h0, 1'h1, 1'h0, FR_RR, 1'h0, ST_INFO);
		ev(EV_RR_RSP, 1'h0, 1'h0, 1'h0, FR_NONE, 1'h0, ST_INFO);
		ev(EV_RR_RSP, 1'h0, 1'h0, 1'h1, FR_I, 1'h0, ST_INFO);
		$display("acknowledge test done");
	endtask

	task automatic t_seq();
		ev(EV_NS_ERR, 1'h0, 1'h1, 1'h0, FR_REJ, 1'h0, ST_REJ);
		ev(EV_NS_ERR, 1'h1, 1'h1, 1'h0, FR_RR, 1'h1, ST_REJ);
		ev(EV_NS_ERR, 1'h0, 1'h1, 1'h0, FR_NONE, 1'h0, ST_REJ);
		ev(EV_I_CMD, 1'h0, 1'h1, 1'h0, FR_RR, 1'h0, ST_INFO);
		$display("sequence test done");
	endtask

	task automatic t_busy();
		ev(EV_BUSY_SET, 1'h0, 1'h0, 1'h0, FR_RNR, 1'h0, ST_LBUSY);
		ev(EV_BUSY_SET, 1'h1, 1'h0, 1'h0, FR_NONE, 1'h0, ST_LBUSY);
		ev(EV_RR_CMD, 1'h0, 1'h1, 1'h0, FR_RNR, 1'h0, ST_LBUSY);
		ev(EV_RR_CMD, 1'h0, 1'h1, 1'h1, FR_I, 1'h0, ST_LBUSY);
		ev(EV_I_CMD, 1'h1, 1'h1, 1'h1, FR_RNR, 1'h1, ST_LBUSY);
		chk_drop(1'h1);
		ev(EV_BUSY_CLR, 1'h0, 1'h0, 1'h0, FR_REJ, 1'h0, ST_INFO);
		chk_drop(1'h0);
		ev(EV_BUSY_SET, 1'h1, 1'h0, 1'h0, FR_RNR, 1'h1, ST_LBUSY);
		ev(EV_BUSY_CLR, 1'h0, 1'h0, 1'h0, FR_RR, 1'h0, ST_INFO);
		$display("busy test done");
	endtask

	task automatic t_stop();
		ev(EV_T1, 1'h0, 1'h0, 1'h0, FR_RR, 1'h1, ST_WAIT);
		ev(EV_STOP, 1'h0, 1'h0, 1'h0, FR_DISC, 1'h1, ST_DISC_REQ);
		ev(EV_UA, 1'h1, 1'h0, 1'h0, FR_NONE, 1'h0, ST_DISC);
		$display("stop test done");
	endtask

	task automatic t_frmr();
		ev(EV_START, 1'h0, 1'h0, 1'h0, FR_SABM, 1'h0, ST_SETUP);
		ev(EV_UA, 1'h1, 1'h0, 1'h0, FR_NONE, 1'h0, ST_INFO);
		ev(EV_UNREC, 1'h0, 1'h0, 1'h0, FR_FRMR, 1'h0, ST_FRMR);
		ev(EV_NS_ERR, 1'h1, 1'h1, 1'h0, FR_FRMR, 1'h1, ST_FRMR);
		ev(EV_NS_ERR, 1'h0, 1'h1, 1'h0, FR_FRMR, 1'h0, ST_FRMR);
		ev(EV_NS_ERR, 1'h1, 1'h0, 1'h0, FR_NONE, 1'h0, ST_FRMR);
		$display("frame reject test done");
	endtask

	task automatic t_misc();
		ev(EV_SABM, 1'h1, 1'h1, 1'h0, FR_UA, 1'h1, ST_INFO);
		ev(EV_RNR_CMD, 1'h0, 1'h1, 1'h0, FR_RR, 1'h0, ST_RBUSY);
		ev(EV_RR_RSP, 1'h0, 1'h0, 1'h1, FR_I, 1'h0, ST_INFO);
		ev(EV_N2, 1'h0, 1'h0, 1'h0, FR_SABM, 1'h0, ST_SETUP);
		ev(EV_DISC, 1'h1, 1'h1, 1'h0, FR_DM, 1'h1, ST_DISC);
		$display("mixed event test done");
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		rst_b = 1'h0;
		n_mismatch = 0;
		samples_checked = 0;
		n_tx = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'h1;
		t_disc();
		t_ack();
		t_seq();
		t_busy();
		t_stop();
		t_frmr();
		t_misc();
		test_done();
	end
endmodule

bind lapb_link_state_responder lapb_responder_checker lapb_responder_checker_inst (
	.clk(clk), .rst_b(rst_b), .tx_valid(tx_valid), .tx_kind(tx_kind), .tx_pf(tx_pf),
	.link_state(link_state), .rej_outstanding(rej_outstanding));
